// File: verilog/fcm_pkg.sv
// fcm_pkg: constants and types for the configuration mode controller
package fcm_pkg;

  // ----------------------------------------------------------------------
  // configuration schemes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FCM_SCHEME_CFG_DEVICE,
    FCM_SCHEME_PASSIVE_SERIAL,
    FCM_SCHEME_PARALLEL_ASYNC,
    FCM_SCHEME_FAST_PARALLEL,
    FCM_SCHEME_TEST_PORT
  } fcm_scheme_e;

  // ----------------------------------------------------------------------
  // sizes, reset values, timing
  // ----------------------------------------------------------------------
  localparam int          FCM_IMAGE_BYTES_DEF = 16;
  localparam int          FCM_FIFO_DEPTH      = 4;
  localparam int          FCM_INIT_CYCLES     = 8;
  localparam int          FCM_CLK_PERIOD_NS   = 40;
  localparam int          FCM_LOAD_LIMIT_MS   = 100;
  localparam int          FCM_LOAD_LIMIT_CYC  = FCM_LOAD_LIMIT_MS * 1000000 / FCM_CLK_PERIOD_NS;
  localparam int          FCM_PLL_CHAIN_BITS  = 24;
  localparam logic [23:0] FCM_PLL_RESET_VAL   = 24'h01_0101;
  localparam logic [7:0]  FCM_BYTE_RESET      = 8'h00;

endpackage : fcm_pkg

// File: verilog/fcm_fifo.sv
// fcm_fifo: small flip-flop FIFO between the configuration source and the loader
`timescale 1ns/1ps
module fcm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // draining side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady,
  // flush
  input  wire logic             flush
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWrite;
  logic             doRead;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (flush) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= bump(wrPtr);
      end
      if (doRead) begin
        rdPtr <= bump(rdPtr);
      end
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end

  property p_no_overflow;
    @(posedge sys_clk) disable iff (!rst_n) count <= (AW+1)'(DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("fifo count above depth");

endmodule : fcm_fifo

// File: verilog/fpga_cfg_mode_ctl.sv
// fpga_cfg_mode_ctl: command/user mode controller with byte loader and pll chain
`timescale 1ns/1ps
// Functional notes
// [R1] after every reset (power-up) the configuration image is loaded again.
// [R2] user pins stay high impedance until initialization ends.
// [R3] after loading, an initialization phase resets user logic, enables pins.
// [R4] command mode covers loading and initialization; user mode comes afterwards.
// [R5] a pin pulse returns user mode to command mode and reloads.
// [R6] five source schemes are accepted; serial ones assemble bits into bytes.
// [R7] loading of byte-wide data finishes well under one hundred milliseconds.
// [R8] devices chain through the chain enable in and out pins.
// [R9] host may feed data serial or parallel, sync or async.
// [R10] host writes every byte to one virtual memory location.
// [R11] loop counters reprogram through a serial chain, from logic or pins.
// [R12] reprogramming the loop counters leaves user mode running.
// [R13] chain enable out asserts only after own configuration completes.
module fpga_cfg_mode_ctl #(
  parameter int IMAGE_BYTES = fcm_pkg::FCM_IMAGE_BYTES_DEF,
  parameter int PLL_BITS    = fcm_pkg::FCM_PLL_CHAIN_BITS
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // mode and chain pins
  input  wire logic                reconfig_n,
  input  wire logic                chain_enable_in_n,
  output logic                     chain_enable_out_n,
  output logic                     cfgDone,
  output logic                     userMode,
  output logic                     userReset_n,
  output logic                     userPinOe_n,
  // scheme select
  input  wire logic [2:0]          scheme,
  // byte-wide sources (device, fast parallel, test port)
  input  wire logic [7:0]          cfgByte,
  input  wire logic                cfgByteValid,
  // serial source (passive serial only)
  input  wire logic                cfgBit,
  input  wire logic                cfgBitValid,
  // asynchronous parallel host: write to one virtual location
  input  wire logic [7:0]          hostData,
  input  wire logic                hostWr_n,
  input  wire logic                hostCs_n,
  output logic                     hostReady,
  // pll counter chain
  input  wire logic                pllShiftEn,
  input  wire logic                pllShiftBit,
  input  wire logic                pllUpdate,
  output logic [PLL_BITS-1:0]      pllCounters,
  output logic                     pllUpdated
);

  // ----------------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FCM_WAIT_ENABLE,
    FCM_LOADING,
    FCM_INIT,
    FCM_USER
  } fcm_mode_e;

  localparam int CW = $clog2(IMAGE_BYTES + 1);
  localparam int IW = $clog2(fcm_pkg::FCM_INIT_CYCLES + 1);

  fcm_mode_e     mode;
  fcm_mode_e     next_mode;
  logic [CW-1:0] byteCount;
  logic [IW-1:0] initCount;
  logic          reconfigPrev;
  logic          reconfigFall;
  logic          loadDone;
  logic          initDone;

  // ----------------------------------------------------------------------
  // source capture
  // ----------------------------------------------------------------------
  logic [7:0] shiftByte;
  logic [2:0] bitCount;
  logic       serialFull;
  logic       hostWrPrev;
  logic       hostStrobe;
  logic [7:0] srcData;
  logic       srcValid;
  logic       fifoInReady;
  logic [7:0] fifoData;
  logic       fifoValid;
  logic       fifoTake;
  logic       loadActive;
  logic [7:0] lastByte;

  function automatic logic is_serial(input logic [2:0] s);
    is_serial = (s == 3'(fcm_pkg::FCM_SCHEME_PASSIVE_SERIAL));
  endfunction : is_serial

  assign loadActive   = (mode == FCM_LOADING);
  assign reconfigFall = reconfigPrev && !reconfig_n;
  assign hostStrobe   = hostWrPrev && !hostWr_n && !hostCs_n;
  assign loadDone     = fifoTake && (byteCount == CW'(IMAGE_BYTES - 1));
  assign initDone     = (initCount == IW'(fcm_pkg::FCM_INIT_CYCLES - 1));
  assign fifoTake     = fifoValid && loadActive;

  // five schemes merge into one byte stream see [R6] see [R9]
  always_comb begin
    srcData  = fcm_pkg::FCM_BYTE_RESET;
    srcValid = 1'b0;
    if (!loadActive) begin
      srcValid = 1'b0;
    end else if (is_serial(scheme)) begin
      srcData  = {shiftByte[6:0], cfgBit};
      srcValid = serialFull;
    end else if (scheme == 3'(fcm_pkg::FCM_SCHEME_PARALLEL_ASYNC)) begin
      srcData  = hostData;
      srcValid = hostStrobe; // see [R10]
    end else if (scheme == 3'(fcm_pkg::FCM_SCHEME_CFG_DEVICE) ||
                 scheme == 3'(fcm_pkg::FCM_SCHEME_FAST_PARALLEL) ||
                 scheme == 3'(fcm_pkg::FCM_SCHEME_TEST_PORT)) begin
      srcData  = cfgByte;
      srcValid = cfgByteValid; // see [R7]
    end
  end

  // serial bits gather msb first; the eighth bit completes the byte
  assign serialFull = loadActive && cfgBitValid && fifoInReady && (bitCount == 3'd7);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftByte <= fcm_pkg::FCM_BYTE_RESET;
      bitCount  <= '0;
    end else if (!loadActive) begin
      bitCount  <= '0;
    end else if (is_serial(scheme) && cfgBitValid && (bitCount != 3'd7 || fifoInReady)) begin
      shiftByte <= {shiftByte[6:0], cfgBit}; // see [R9]
      bitCount  <= bitCount + 3'd1;
    end
  end

  // host write edge detect; pins taken as synchronous
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hostWrPrev   <= 1'b1;
      reconfigPrev <= 1'b1;
    end else begin
      hostWrPrev   <= hostWr_n;
      reconfigPrev <= reconfig_n;
    end
  end

  // host sees ready only while the fifo can take its next byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hostReady <= 1'b0;
    end else begin
      hostReady <= loadActive && fifoInReady;
    end
  end

  // ----------------------------------------------------------------------
  // fifo in the data path
  // ----------------------------------------------------------------------
  fcm_fifo #(
    .WIDTH (8),
    .DEPTH (fcm_pkg::FCM_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .inData   (srcData),
    .inValid  (srcValid),
    .inReady  (fifoInReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (loadActive),
    .flush    (!loadActive)
  );

  // loaded bytes land in configuration storage; only the last is kept here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastByte <= fcm_pkg::FCM_BYTE_RESET;
    end else if (fifoTake) begin
      lastByte <= fifoData;
    end
  end

  // ----------------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    case (mode)
      FCM_WAIT_ENABLE: begin
        if (!chain_enable_in_n) begin
          next_mode = FCM_LOADING; // see [R8]
        end
      end
      FCM_LOADING: begin
        if (loadDone) begin
          next_mode = FCM_INIT; // see [R3]
        end
      end
      FCM_INIT: begin
        if (initDone) begin
          next_mode = FCM_USER; // see [R4]
        end
      end
      FCM_USER: begin
        next_mode = FCM_USER;
      end
      default: begin
        next_mode = FCM_WAIT_ENABLE;
      end
    endcase
    if (reconfigFall) begin
      next_mode = FCM_WAIT_ENABLE; // see [R5]
    end
  end

  // reset is the power-up: storage is volatile, so loading starts over see [R1]
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= FCM_WAIT_ENABLE;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      byteCount <= '0;
    end else if (!loadActive) begin
      byteCount <= '0;
    end else if (fifoTake) begin
      byteCount <= byteCount + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      initCount <= '0;
    end else if (mode != FCM_INIT) begin
      initCount <= '0;
    end else begin
      initCount <= initCount + IW'(1);
    end
  end

  // ----------------------------------------------------------------------
  // pin and user-logic controls
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      userPinOe_n        <= 1'b1;
      userReset_n        <= 1'b0;
      userMode           <= 1'b0;
      cfgDone            <= 1'b0;
      chain_enable_out_n <= 1'b1;
    end else begin
      userPinOe_n        <= (next_mode != FCM_USER); // see [R2]
      userReset_n        <= (next_mode == FCM_USER); // see [R3]
      userMode           <= (next_mode == FCM_USER); // see [R4]
      cfgDone            <= (next_mode == FCM_INIT) || (next_mode == FCM_USER);
      chain_enable_out_n <= !((next_mode == FCM_INIT) || (next_mode == FCM_USER)); // see [R13]
    end
  end

  // ----------------------------------------------------------------------
  // pll counter chain: shadow shifts, live copy updates without reload
  // ----------------------------------------------------------------------
  logic [PLL_BITS-1:0] pllShadow;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pllShadow <= PLL_BITS'(fcm_pkg::FCM_PLL_RESET_VAL);
    end else if (pllShiftEn) begin
      pllShadow <= {pllShadow[PLL_BITS-2:0], pllShiftBit}; // see [R11]
    end
  end

  // the live copy changes only on update, so the loop never sees half a word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pllCounters <= PLL_BITS'(fcm_pkg::FCM_PLL_RESET_VAL);
      pllUpdated  <= 1'b0;
    end else begin
      pllUpdated <= pllUpdate;
      if (pllUpdate) begin
        pllCounters <= pllShadow; // see [R12]
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_pins_off_in_command;
    @(posedge sys_clk) disable iff (!rst_n) !userMode |-> userPinOe_n;
  endproperty
  a_pins_off_in_command: assert property (p_pins_off_in_command) // see [R2]
    else $error("user pins enabled outside user mode");

  property p_init_after_load;
    @(posedge sys_clk) disable iff (!rst_n)
      (loadDone && !reconfigFall) |=> (mode == FCM_INIT) && !userMode;
  endproperty
  a_init_after_load: assert property (p_init_after_load) // see [R3]
    else $error("no initialization after loading");

  // a reconfig pulse may legally cut initialization short, so it ends the attempt
  property p_init_length;
    @(posedge sys_clk) disable iff (!rst_n || !reconfig_n)
      $rose(mode == FCM_INIT) |-> (mode == FCM_INIT)[*8] ##1 (mode == FCM_USER);
  endproperty
  a_init_length: assert property (p_init_length) // see [R4]
    else $error("initialization phase wrong length");

  property p_reconfig_leaves_user;
    @(posedge sys_clk) disable iff (!rst_n) reconfigFall |=> !userMode && userPinOe_n;
  endproperty
  a_reconfig_leaves_user: assert property (p_reconfig_leaves_user) // see [R5]
    else $error("reconfig pulse did not leave user mode");

  property p_wait_chain;
    @(posedge sys_clk) disable iff (!rst_n)
      (mode == FCM_WAIT_ENABLE && chain_enable_in_n) |=> (mode != FCM_LOADING);
  endproperty
  a_wait_chain: assert property (p_wait_chain) // see [R8]
    else $error("loading began without chain enable");

  property p_chain_out_after_done;
    @(posedge sys_clk) disable iff (!rst_n)
      !chain_enable_out_n |-> cfgDone && (mode == FCM_INIT || mode == FCM_USER);
  endproperty
  a_chain_out_after_done: assert property (p_chain_out_after_done) // see [R13]
    else $error("chain enable out before done");

  property p_pll_update;
    @(posedge sys_clk) disable iff (!rst_n)
      (pllUpdate && !pllShiftEn) |=> (pllCounters == $past(pllShadow)) && pllUpdated;
  endproperty
  a_pll_update: assert property (p_pll_update) // see [R11]
    else $error("pll counters not updated");

  property p_pll_keeps_user;
    @(posedge sys_clk) disable iff (!rst_n)
      (userMode && pllShiftEn && reconfig_n) |=> userMode;
  endproperty
  a_pll_keeps_user: assert property (p_pll_keeps_user) // see [R12]
    else $error("pll reprogramming disturbed user mode");

  property p_byte_count;
    @(posedge sys_clk) disable iff (!rst_n)
      (fifoTake && !reconfigFall) |=> (byteCount == $past(byteCount) + CW'(1)) || !loadActive;
  endproperty
  a_byte_count: assert property (p_byte_count) // see [R7]
    else $error("byte not counted");

  c_reach_user:  cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(userMode));
  c_reconfig:    cover property (@(posedge sys_clk) disable iff (!rst_n) userMode && reconfigFall);
  c_host_write:  cover property (@(posedge sys_clk) disable iff (!rst_n) hostStrobe && srcValid);
  c_serial_byte: cover property (@(posedge sys_clk) disable iff (!rst_n) serialFull && srcValid);

endmodule : fpga_cfg_mode_ctl

// File: testbench/fcm_cfg_source.sv
// fcm_cfg_source: behavioural configuration source feeding the loader
`timescale 1ns/1ps
module fcm_cfg_source (
  // clock
  input  wire logic       sys_clk,
  // byte source
  output logic      [7:0] cfgByte,
  output logic            cfgByteValid,
  // serial source
  output logic            cfgBit,
  output logic            cfgBitValid,
  // host source
  output logic      [7:0] hostData,
  output logic            hostWr_n,
  output logic            hostCs_n,
  input  wire logic       hostReady
);
  int gap;

  initial begin
    cfgByte      = 8'h00;
    cfgByteValid = 1'b0;
    cfgBit       = 1'b0;
    cfgBitValid  = 1'b0;
    hostData     = 8'h00;
    hostWr_n     = 1'b1;
    hostCs_n     = 1'b1;
    gap          = 1;
  end

  // released lines show the inverse of the last value, never a stale copy
  task automatic send(input int s, input logic [7:0] b);
    int k;
    if (s == 1) begin
      for (k = 7; k >= 0; k--) begin
        @(posedge sys_clk);
        cfgBit      <= b[k];
        cfgBitValid <= 1'b1;
        @(posedge sys_clk);
        cfgBit      <= ~b[k];
        cfgBitValid <= 1'b0;
      end
    end else if (s == 2) begin
      k = 0;
      // ready is a registered output: look at it only where it has settled
      @(negedge sys_clk);
      while (hostReady !== 1'b1 && k < 50) begin
        @(negedge sys_clk);
        k++;
      end
      @(posedge sys_clk);
      hostData <= b;
      hostCs_n <= 1'b0;
      @(posedge sys_clk);
      hostWr_n <= 1'b0;
      @(posedge sys_clk);
      hostWr_n <= 1'b1;
      hostCs_n <= 1'b1;
      hostData <= ~b;
    end else begin
      @(posedge sys_clk);
      cfgByte      <= b;
      cfgByteValid <= 1'b1;
      @(posedge sys_clk);
      cfgByte      <= ~b;
      cfgByteValid <= 1'b0;
    end
    repeat (gap) @(posedge sys_clk);
  endtask : send
endmodule : fcm_cfg_source

// File: testbench/fpga_config_mode_control_test.sv
// fpga_config_mode_control_test: self-checking bench for the mode controller
`timescale 1ns/1ps
module fpga_config_mode_control_test;
  localparam int IMG = fcm_pkg::FCM_IMAGE_BYTES_DEF;
  logic        sys_clk, rst_n, reconfig_n, chain_enable_in_n;
  logic        pllShiftEn, pllShiftBit, pllUpdate, pllUpdated;
  logic [2:0]  scheme;
  logic [7:0]  cfgByte, hostData;
  logic        cfgByteValid, cfgBit, cfgBitValid, hostWr_n, hostCs_n, hostReady;
  logic        chain_enable_out_n, cfgDone, userMode, userReset_n, userPinOe_n;
  logic [23:0] pllCounters, exp;
  logic        r;
  logic [7:0]  lastSent;
  int          n_fail, checks_done, cyc, t0, k, initSeen;

  fpga_cfg_mode_ctl #(.IMAGE_BYTES(IMG)) u_fpga_cfg_mode_ctl (
    .sys_clk(sys_clk), .rst_n(rst_n), .reconfig_n(reconfig_n),
    .chain_enable_in_n(chain_enable_in_n), .chain_enable_out_n(chain_enable_out_n),
    .cfgDone(cfgDone), .userMode(userMode), .userReset_n(userReset_n),
    .userPinOe_n(userPinOe_n), .scheme(scheme), .cfgByte(cfgByte),
    .cfgByteValid(cfgByteValid), .cfgBit(cfgBit), .cfgBitValid(cfgBitValid),
    .hostData(hostData), .hostWr_n(hostWr_n), .hostCs_n(hostCs_n), .hostReady(hostReady),
    .pllShiftEn(pllShiftEn), .pllShiftBit(pllShiftBit), .pllUpdate(pllUpdate),
    .pllCounters(pllCounters), .pllUpdated(pllUpdated));
  fcm_cfg_source u_fcm_cfg_source (
    .sys_clk(sys_clk), .cfgByte(cfgByte), .cfgByteValid(cfgByteValid), .cfgBit(cfgBit),
    .cfgBitValid(cfgBitValid), .hostData(hostData), .hostWr_n(hostWr_n),
    .hostCs_n(hostCs_n), .hostReady(hostReady));

  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  // initialization length seen from the pins, independent of when the bench looks
  always @(posedge sys_clk) begin
    if (!cfgDone) initSeen <= 0;
    else if (!userMode) initSeen <= initSeen + 1;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic complete_run;
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic send_n(input int s, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      lastSent = 8'($urandom);
      u_fcm_cfg_source.send(s, lastSent);
    end
  endtask : send_n

  // reconfig is edge-triggered, so one low cycle suffices
  task automatic pulse_reconfig;
    @(posedge sys_clk);
    reconfig_n <= 1'b0;
    @(posedge sys_clk);
    reconfig_n <= 1'b1;
    @(negedge sys_clk);
    check(userMode, 0);
    check(userPinOe_n, 1);
  endtask : pulse_reconfig

  task automatic load_image(input int s);
    t0 = cyc;
    send_n(s, IMG - 1);
    repeat (6) @(negedge sys_clk);
    check(cfgDone, 0);
    check(userPinOe_n, 1);
    check(userReset_n, 0);
    check(chain_enable_out_n, 1);
    check(hostReady, 1);
    send_n(s, 1);
    k = 0;
    @(negedge sys_clk);
    while (cfgDone !== 1'b1 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    check(cfgDone, 1);
    check(chain_enable_out_n, 0);
    check(userMode, 0);
    check(userPinOe_n, 1);
    check(u_fpga_cfg_mode_ctl.lastByte, lastSent);
    check((cyc - t0) < fcm_pkg::FCM_LOAD_LIMIT_CYC, 1);
    k = 0;
    while (userMode !== 1'b1 && k < 50) begin
      @(negedge sys_clk);
      k++;
    end
    check(initSeen, fcm_pkg::FCM_INIT_CYCLES);
    check(userPinOe_n, 0);
    check(userReset_n, 1);
    check(hostReady, 0);
  endtask : load_image

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    sys_clk           = 1'b0;
    rst_n             = 1'b0;
    reconfig_n        = 1'b1;
    chain_enable_in_n = 1'b1;
    scheme            = 3'h0;
    pllShiftEn        = 1'b0;
    pllShiftBit       = 1'b0;
    pllUpdate         = 1'b0;
    lastSent          = 8'h00;
    n_fail            = 0;
    checks_done       = 0;
    cyc               = 0;
    initSeen          = 0;
    void'($urandom(64614));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check(cfgDone, 0);
    check(userPinOe_n, 1);
    check(pllCounters, fcm_pkg::FCM_PLL_RESET_VAL);
    // bytes offered before the chain enable are dropped
    send_n(0, IMG);
    @(negedge sys_clk);
    check(cfgDone, 0);
    check(hostReady, 0);
    @(posedge sys_clk);
    chain_enable_in_n <= 1'b0;
    for (int s = 0; s < 5; s++) begin
      u_fcm_cfg_source.gap = 1 + ($urandom % 3);
      @(posedge sys_clk);
      scheme <= 3'(s);
      pulse_reconfig;
      send_n(s, $urandom_range(IMG - 1, 1));
      pulse_reconfig; // partial image must be thrown away
      load_image(s);
    end
    // loop counters reprogrammed while in user mode
    exp = fcm_pkg::FCM_PLL_RESET_VAL;
    for (int i = 0; i < fcm_pkg::FCM_PLL_CHAIN_BITS; i++) begin
      @(posedge sys_clk);
      r            = 1'($urandom);
      pllShiftEn  <= 1'b1;
      pllShiftBit <= r;
      exp          = {exp[22:0], r};
    end
    // shifting alone must leave the live counters untouched
    @(negedge sys_clk);
    check(pllCounters, fcm_pkg::FCM_PLL_RESET_VAL);
    @(posedge sys_clk);
    pllShiftEn <= 1'b0;
    pllUpdate  <= 1'b1;
    @(posedge sys_clk);
    pllUpdate <= 1'b0;
    @(negedge sys_clk);
    check(pllUpdated, 1);
    check(pllCounters, exp);
    check(userMode, 1);
    // second power-up in mid-run forces a full reload
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check(userMode, 0);
    check(userPinOe_n, 1);
    load_image(3);
    complete_run;
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    complete_run;
  end
endmodule : fpga_config_mode_control_test
